// ===== scene_pkg.sv
// Purpose: shared constants and types for the scene control input channel
// Assumes: 250 MHz system clock, 16-bit register port
// Notes:   offsets are byte addresses, one word per register
package scene_pkg;
  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int unsigned CLK_MHZ    = 250;   // system clock rate
  localparam int unsigned TICK_MS    = 10;    // time base tick, ms
  localparam int unsigned TICK_CYC   = TICK_MS * 1000 * CLK_MHZ;
  localparam int unsigned TICK_W     = 22;    // tick counter width
  localparam int unsigned NGRP       = 6;     // actuator groups
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] A_CTRL  = 8'h00;     // control word
  localparam logic [7:0] A_TYPES = 8'h04;     // group types, 2 bits each
  localparam logic [7:0] A_PART  = 8'h08;     // bus-store mask
  localparam logic [7:0] A_STAT  = 8'h0c;     // status, read only
  localparam logic [7:0] A_PRE0  = 8'h10;     // preset of group 0
  localparam logic [7:0] A_SCN0  = 8'h30;     // value of group 0, read
  localparam logic [7:0] A_SPAN  = 8'h18;     // six words
  // control fields
  localparam int unsigned C_MODE = 0;         // store mode, 2 bits
  localparam int unsigned C_LONG = 2;         // long index, 5 bits
  localparam int unsigned C_DEB  = 7;         // debounce index, 3 bits
  localparam int unsigned C_OPEN = 10;        // actuation opens contact
  localparam int unsigned C_IDX  = 11;        // input number, 3 bits
  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0008;  // long index 2
  localparam logic [11:0] TYPES_RST = 12'h555;   // all percentage
  localparam logic [5:0]  PART_RST  = 6'h3f;     // all take part
  localparam logic [15:0] PRE_RST   = 16'h0001;  // one ten, 10 %
  // ****************************************************************
  // object numbering inside one input block
  // ****************************************************************
  localparam logic [6:0] OBJ_STRIDE  = 7'h0a;
  localparam logic [6:0] OBJ_BLOCK   = 7'h00;
  localparam logic [6:0] OBJ_GRP0    = 7'h01;
  localparam logic [6:0] OBJ_STORE   = 7'h07;
  localparam logic [6:0] OBJ_IND     = 7'h08;
  localparam logic [6:0] OBJ_RESTORE = 7'h09;
  // ****************************************************************
  // tables; press and debounce times counted in 10 ms ticks
  // ****************************************************************
  localparam logic [9:0] LONG_TICKS [17] = '{
    10'h01e, 10'h028, 10'h032, 10'h03c, 10'h050, 10'h064, 10'h078,
    10'h096, 10'h0c8, 10'h12c, 10'h190, 10'h1f4, 10'h258, 10'h2bc,
    10'h320, 10'h384, 10'h3e8};
  localparam logic [4:0] LONG_MAX = 5'h10;
  localparam logic [3:0] DEB_TICKS [7] = '{
    4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'ha, 4'hf};
  localparam logic [7:0] PCT_LUT [11] = '{
    8'h00, 8'h1a, 8'h33, 8'h4d, 8'h66, 8'h80, 8'h99, 8'hb3, 8'hcc,
    8'he6, 8'hff};
  localparam logic signed [17:0] TEMP_MAX = 18'sh02710;  // 100,00
  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [1:0] {MODE_NONE, MODE_LONG, MODE_OBJ, MODE_BOTH} store_mode_t;
  typedef enum logic [1:0] {GT_BIT, GT_PCT, GT_CNT, GT_TEMP} grp_type_t;
  typedef enum logic [2:0] {S_IDLE, S_SEND, S_RDREQ, S_WAIT, S_IND} state_t;
endpackage

// ===== scene_channel.sv
// Purpose: one contact input in scene control mode
// Assumes: object bus adapter on clk_i with valid/ready transmit side
// Notes:   configuration reached over the plain register port
//
// Contract
// - long press starts save in long mode
// - store object value 1 starts save in object mode
// - combined mode needs long press and enable
// - save reads group values over the bus
// - indication 1 after all responses arrive
// - early release sends 0, scene kept
// - long time selectable 0.3 to 10 s
// - six groups, each with own type
// - actuation sends each group's preset
// - encode per switch, percent, counter, temperature
// - restore object 1 brings presets back
// - per-group option for bus saving
// - ten object numbers per input
// - block object 0 enables, 1 disables
// - blocked input ignores contact, press timer held
// - blocking mid-save still completes the save
// - on unblock, changed contact handled at once
// - manual operation unaffected by block
// - react at once, then debounce interval
// - contact type sets actuation polarity
`timescale 1ns/1ns
`default_nettype none
module scene_channel
  import scene_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC  // cycles per 10 ms tick
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        contact_i,      // contact pin, asynchronous
  input  wire logic        manual_en_i,    // manual operation active
  input  wire logic        manual_act_i,   // simulated actuation
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        obj_wr_i,       // object value from bus
  input  wire logic        obj_resp_i,     // value is a read response
  input  wire logic [6:0]  obj_num_i,
  input  wire logic [15:0] obj_val_i,
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic             tx_read_o,      // read request, no value
  output logic      [6:0]  tx_num_o,
  output logic      [15:0] tx_val_o,
  output logic             blocked_o
);
  // ****************************************************************
  // helper functions
  // ****************************************************************
  // first object number of an input
  function automatic logic [6:0] obj_base(input logic [2:0] idx);
    obj_base = (7'(idx) + 7'h01) * OBJ_STRIDE;
  endfunction
  // word slot inside a six-word window
  function automatic logic [3:0] slot(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] off;
    off = a - b;
    slot = 4'h0;
    if (a >= b && off < A_SPAN && off[1:0] == 2'b00) begin
      slot = {1'b1, off[4:2]};
    end
  endfunction
  // preset to wire format
  function automatic logic [15:0] enc(input logic [1:0] t, input logic [15:0] p);
    logic signed [17:0] m;
    logic [3:0]         e;
    m   = 18'(signed'(p));
    e   = 4'h0;
    enc = 16'h0000;
    case (grp_type_t'(t))
      GT_BIT:  enc = {15'h0000, p[0]};
      GT_PCT:  enc = {8'h00, PCT_LUT[(p > 16'h000a) ? 4'ha : p[3:0]]};
      GT_CNT:  enc = {8'h00, p[7:0]};
      default: begin
        if (m > TEMP_MAX) m = TEMP_MAX;
        if (m < -TEMP_MAX) m = -TEMP_MAX;
        for (int i = 0; i < 4; i++) begin
          if (m > 18'sh007ff || m < -18'sh00800) begin
            m = m >>> 1;
            e = e + 4'h1;
          end
        end
        enc = {m[17], e, m[10:0]};
      end
    endcase
  endfunction
  // ****************************************************************
  // state declarations
  // ****************************************************************
  logic [15:0]       ctrl_q, ctrl_d;             // control word
  logic [11:0]       types_q, types_d;           // group types
  logic [5:0]        part_q, part_d;             // bus-store mask
  logic [15:0]       pre_q [NGRP];               // presets
  logic [15:0]       pre_d [NGRP];
  logic [15:0]       rdata_q, rdata_d;           // read answer
  logic              sync1_q, sync2_q;           // pin synchroniser
  logic [TICK_W-1:0] tick_q, tick_d;             // time base
  logic              act_q, act_d;               // accepted actuation
  logic [3:0]        deb_q, deb_d;               // debounce left
  logic [9:0]        long_q, long_d;             // press duration
  logic              long_done_q, long_done_d;
  logic              press_q, press_d;           // press event
  logic              long_hit_q, long_hit_d;     // long event
  logic              block_q, block_d;           // block object
  logic              en_store_q, en_store_d;     // enable storing
  logic              saved_q, saved_d;           // scene from bus
  logic [15:0]       scene_q [NGRP];             // saved values
  logic [15:0]       scene_d [NGRP];
  logic [15:0]       cap_q [NGRP];               // read responses
  logic [15:0]       cap_d [NGRP];
  logic [5:0]        need_q, need_d;             // groups to read
  logic [5:0]        got_q, got_d;               // responses seen
  logic              by_btn_q, by_btn_d;         // save from button
  logic [2:0]        grp_q, grp_d;               // group iterator
  state_t            state_q, state_d;
  logic              txv_q, txv_d;
  logic              txr_q, txr_d;
  logic [6:0]        txn_q, txn_d;
  logic [15:0]       txw_q, txw_d;
  // decoded control fields and derived signals
  store_mode_t       mode;
  logic [4:0]        long_idx;
  logic [6:0]        base;
  logic              tick;
  logic              raw_act;
  logic              src_act;
  logic              blk_eff;
  logic [9:0]        long_lim;
  logic [6:0]        rel;
  logic              abort;
  logic              all_got;
  assign mode     = store_mode_t'(ctrl_q[C_MODE +: 2]);
  assign long_idx = (ctrl_q[C_LONG +: 5] > LONG_MAX) ? LONG_MAX : ctrl_q[C_LONG +: 5];
  assign long_lim = LONG_TICKS[long_idx];
  assign base     = obj_base(ctrl_q[C_IDX +: 3]);
  assign tick     = (tick_q == TICK_W'(TICK_CYCLES - 1));
  assign rel      = obj_num_i - base;
  // value sent for a group
  function automatic logic [15:0] cur_val(input logic [2:0] g);
    cur_val = saved_q ? scene_q[g] : enc(types_q[2*g +: 2], pre_q[g]);
  endfunction
  // ****************************************************************
  // register port
  // ****************************************************************
  // writes steer the block, reads answer one cycle later
  always_comb begin
    logic [3:0] ps;
    logic [3:0] ss;
    ps      = slot(reg_addr_i, A_PRE0);
    ss      = slot(reg_addr_i, A_SCN0);
    ctrl_d  = ctrl_q;
    types_d = types_q;
    part_d  = part_q;
    pre_d   = pre_q;
    rdata_d = 16'h0000;                          // idle and unmapped read zero
    if (reg_wr_i) begin
      case (reg_addr_i)
        A_CTRL:  ctrl_d  = reg_wdata_i;
        A_TYPES: types_d = reg_wdata_i[11:0];
        A_PART:  part_d  = reg_wdata_i[5:0];
        default: if (ps[3]) pre_d[ps[2:0]] = reg_wdata_i;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        A_CTRL:  rdata_d = ctrl_q;
        A_TYPES: rdata_d = {4'h0, types_q};
        A_PART:  rdata_d = {10'h000, part_q};
        A_STAT:  rdata_d = {8'h00, act_q, block_q, saved_q, en_store_q, 1'b0, 3'(state_q)};
        default: begin
          if (ps[3]) rdata_d = pre_q[ps[2:0]];
          else if (ss[3]) rdata_d = cur_val(ss[2:0]);
        end
      endcase
    end
  end
  // register port storage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q  <= CTRL_RST;
      types_q <= TYPES_RST;
      part_q  <= PART_RST;
      for (int g = 0; g < NGRP; g++) pre_q[g] <= PRE_RST;
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q  <= ctrl_d;
      types_q <= types_d;
      part_q  <= part_d;
      pre_q   <= pre_d;
      rdata_q <= rdata_d;
    end
  end
  // ****************************************************************
  // contact input, debounce and press timing
  // ****************************************************************
  // two flip-flops before the pin is read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= contact_i;
      sync2_q <= sync1_q;
    end
  end
  assign raw_act = ctrl_q[C_OPEN] ? ~sync2_q : sync2_q;
  assign src_act = manual_en_i ? manual_act_i : raw_act;
  assign blk_eff = block_q & ~manual_en_i;
  // edge accept, debounce, long press counting
  always_comb begin
    tick_d      = tick ? '0 : tick_q + TICK_W'(1);
    act_d       = act_q;
    deb_d       = deb_q;
    long_d      = long_q;
    long_done_d = long_done_q;
    press_d     = 1'b0;
    long_hit_d  = 1'b0;
    if (deb_q != 4'h0 && tick) begin
      deb_d = deb_q - 4'h1;
    end
    // blocked: contact ignored; on release a differing level is taken
    if (!blk_eff && deb_q == 4'h0 && src_act != act_q) begin
      act_d   = src_act;
      deb_d   = DEB_TICKS[(ctrl_q[C_DEB +: 3] > 3'h6) ? 3'h6 : ctrl_q[C_DEB +: 3]];
      press_d = src_act;
    end
    if (!act_q) begin
      long_d      = 10'h000;
      long_done_d = 1'b0;
    end else if (!blk_eff && tick && !long_done_q) begin
      long_d = long_q + 10'h001;
      if (long_d >= long_lim) begin
        long_done_d = 1'b1;
        long_hit_d  = 1'b1;
      end
    end
  end
  // input timing state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tick_q      <= '0;
      act_q       <= 1'b0;
      deb_q       <= 4'h0;
      long_q      <= 10'h000;
      long_done_q <= 1'b0;
      press_q     <= 1'b0;
      long_hit_q  <= 1'b0;
    end else begin
      tick_q      <= tick_d;
      act_q       <= act_d;
      deb_q       <= deb_d;
      long_q      <= long_d;
      long_done_q <= long_done_d;
      press_q     <= press_d;
      long_hit_q  <= long_hit_d;
    end
  end
  // ****************************************************************
  // scene sequencer
  // ****************************************************************
  assign all_got = ((got_q & need_q) == need_q);
  // a blocked input cannot release, so the save runs on
  assign abort   = by_btn_q & ~act_q & ~blk_eff;
  // objects in, sending, save and restore
  always_comb begin
    logic store_wr;
    store_wr   = obj_wr_i && !obj_resp_i && rel == OBJ_STORE;
    state_d    = state_q;
    grp_d      = grp_q;
    need_d     = need_q;
    got_d      = got_q;
    cap_d      = cap_q;
    scene_d    = scene_q;
    saved_d    = saved_q;
    by_btn_d   = by_btn_q;
    block_d    = block_q;
    en_store_d = en_store_q;
    txv_d      = txv_q;
    txr_d      = txr_q;
    txn_d      = txn_q;
    txw_d      = txw_q;
    if (obj_wr_i && !obj_resp_i && rel == OBJ_BLOCK) begin
      block_d = obj_val_i[0];
    end
    if (store_wr && mode == MODE_BOTH) begin
      en_store_d = obj_val_i[0];
    end
    // read responses of the groups being saved
    if (obj_wr_i && obj_resp_i && rel >= OBJ_GRP0 && rel < OBJ_GRP0 + 7'(NGRP)) begin
      cap_d[3'(rel - OBJ_GRP0)] = obj_val_i;
      got_d[3'(rel - OBJ_GRP0)] = 1'b1;
    end
    if (obj_wr_i && !obj_resp_i && rel == OBJ_RESTORE && obj_val_i[0]) begin
      saved_d = 1'b0;
    end
    case (state_q)
      S_IDLE: begin
        grp_d = 3'h0;
        got_d = 6'h00;
        if (press_q) begin
          state_d = S_SEND;
        end else if ((long_hit_q && mode == MODE_LONG)
                  || (long_hit_q && mode == MODE_BOTH && en_store_q)
                  || (store_wr && obj_val_i[0] && mode == MODE_OBJ)) begin
          state_d  = S_RDREQ;
          need_d   = part_q;
          by_btn_d = long_hit_q;
        end
      end
      S_SEND, S_RDREQ: begin
        if (!txv_q || tx_ready_i) begin
          txv_d = 1'b0;
          if (grp_q == 3'(NGRP)) begin
            state_d = (state_q == S_SEND) ? S_IDLE : S_WAIT;
          end else begin
            if (state_q == S_SEND || need_q[grp_q]) begin
              txv_d = 1'b1;
              txr_d = (state_q == S_RDREQ);
              txn_d = base + OBJ_GRP0 + 7'(grp_q);
              txw_d = (state_q == S_SEND) ? cur_val(grp_q) : 16'h0000;
            end
            grp_d = grp_q + 3'h1;
          end
        end
      end
      S_WAIT: begin
        // no timeout: waits for all responses, or for release on a button save
        if (all_got) begin
          for (int g = 0; g < NGRP; g++) begin
            scene_d[g] = need_q[g] ? cap_q[g] : cur_val(3'(g));
          end
          saved_d = 1'b1;
          state_d = S_IND;
          txv_d   = 1'b1;
          txr_d   = 1'b0;
          txn_d   = base + OBJ_IND;
          txw_d   = 16'h0001;
        end else if (abort) begin
          state_d = S_IND;
          txv_d   = 1'b1;
          txr_d   = 1'b0;
          txn_d   = base + OBJ_IND;
          txw_d   = 16'h0000;
        end
      end
      S_IND: begin
        if (tx_ready_i) begin
          txv_d   = 1'b0;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end
  // sequencer state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q    <= S_IDLE;
      grp_q      <= 3'h0;
      need_q     <= 6'h00;
      got_q      <= 6'h00;
      saved_q    <= 1'b0;
      by_btn_q   <= 1'b0;
      block_q    <= 1'b0;
      en_store_q <= 1'b0;
      txv_q      <= 1'b0;
      txr_q      <= 1'b0;
      txn_q      <= 7'h00;
      txw_q      <= 16'h0000;
      for (int g = 0; g < NGRP; g++) begin
        scene_q[g] <= 16'h0000;
        cap_q[g]   <= 16'h0000;
      end
    end else begin
      state_q    <= state_d;
      grp_q      <= grp_d;
      need_q     <= need_d;
      got_q      <= got_d;
      saved_q    <= saved_d;
      by_btn_q   <= by_btn_d;
      block_q    <= block_d;
      en_store_q <= en_store_d;
      txv_q      <= txv_d;
      txr_q      <= txr_d;
      txn_q      <= txn_d;
      txw_q      <= txw_d;
      scene_q    <= scene_d;
      cap_q      <= cap_d;
    end
  end
  // outputs straight from flip-flops
  assign reg_rdata_o = rdata_q;
  assign tx_valid_o  = txv_q;
  assign tx_read_o   = txr_q;
  assign tx_num_o    = txn_q;
  assign tx_val_o    = txw_q;
  assign blocked_o   = block_q;
  // ****************************************************************
  // checks
  // ****************************************************************
  chk_long_save: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == S_IDLE && !press_q && long_hit_q && mode == MODE_LONG)
    |=> (state_q == S_RDREQ && need_q == $past(part_q)))
    else $error("long press did not start save");
  chk_obj_save: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == S_IDLE && !press_q && mode == MODE_OBJ && obj_wr_i && !obj_resp_i
     && rel == OBJ_STORE && obj_val_i[0]) |=> (state_q == S_RDREQ))
    else $error("store object did not start save");
  chk_both_gate: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == S_IDLE && mode == MODE_BOTH && !en_store_q) |=> (state_q != S_RDREQ))
    else $error("combined mode saved without enable");
  chk_ind_one: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == S_WAIT && all_got) |=> (txv_q && txw_q == 16'h0001
     && txn_q == base + OBJ_IND && saved_q))
    else $error("indication 1 missing after responses");
  chk_abort_keep: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (state_q == S_WAIT && !all_got && abort)
    |=> (txw_q == 16'h0000 && $stable(scene_q[0]) && $stable(saved_q)))
    else $error("early release did not abandon save");
  chk_long_time: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(long_done_q) |-> (long_q == $past(long_lim) && $past(act_q)))
    else $error("long press at wrong duration");
  chk_block_hold: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (blk_eff && act_q) |=> ($stable(act_q) && $stable(long_q)))
    else $error("blocked input changed timing");
  chk_press_clear: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !act_q |=> (long_q == 10'h000 && !long_done_q))
    else $error("press counter not cleared");
  chk_deb_quiet: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $changed(act_q) |-> (deb_q != 4'h0) ##1 $stable(act_q))
    else $error("edge accepted inside debounce");
  chk_num_range: assert property (
    @(posedge clk_i) disable iff (reset_i)
    txv_q |-> (txn_q >= base && txn_q <= base + OBJ_RESTORE))
    else $error("object number outside input block");
  chk_restore: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (obj_wr_i && !obj_resp_i && rel == OBJ_RESTORE && obj_val_i[0]
     && !(state_q == S_WAIT && all_got)) |=> !saved_q)
    else $error("restore did not return presets");
endmodule // scene_channel
`default_nettype wire

// ===== bus_model.sv
// Purpose: far side of the object bus, answers group reads
// Assumes: one outstanding read, bench object writes when quiet
// Notes:   ready toggles, so every word waits one cycle or none
`timescale 1ns/1ns
`default_nettype none
module bus_model (
  input  wire logic        clk_i,
  input  wire logic        tx_valid_i,
  input  wire logic        tx_read_i,
  input  wire logic [6:0]  tx_num_i,
  input  wire logic [15:0] tx_val_i,
  input  wire logic        mute_i,     // withhold read feedback
  input  wire logic        cmd_wr_i,   // bench object write
  input  wire logic [6:0]  cmd_num_i,
  input  wire logic [15:0] cmd_val_i,
  output logic             tx_ready_o,
  output logic             obj_wr_o,
  output logic             obj_resp_o,
  output logic [6:0]       obj_num_o,
  output logic [15:0]      obj_val_o,
  output logic [15:0]      ind_o,      // last indication seen
  output int               wr_cnt_o    // group writes seen
);
  logic       rsp_q = 1'b0;            // feedback pulse
  logic [6:0] num_q = 7'h00;           // object being answered
  logic       acc;                     // word taken this edge
  assign acc = tx_valid_i & tx_ready_o;
  initial ind_o = 16'hffff;
  initial wr_cnt_o = 0;
  initial tx_ready_o = 1'b0;
  // slow and prompt answers in turn
  always @(posedge clk_i) begin
    tx_ready_o <= ~tx_ready_o;
    rsp_q <= acc & tx_read_i & ~mute_i;
    if (acc) num_q <= tx_num_i;
    if (acc & ~tx_read_i & (tx_num_i == 7'h12)) ind_o <= tx_val_i;
    if (acc & ~tx_read_i & (tx_num_i inside {[7'h0b:7'h10]})) wr_cnt_o <= wr_cnt_o + 1;
  end
  // idle lines show the inverse of the last object
  assign obj_wr_o   = cmd_wr_i | rsp_q;
  assign obj_resp_o = rsp_q & ~cmd_wr_i;
  assign obj_num_o  = cmd_wr_i ? cmd_num_i : (rsp_q ? num_q : ~num_q);
  assign obj_val_o  = cmd_wr_i ? cmd_val_i : {9'h000, rsp_q ? num_q : ~num_q};
endmodule // bus_model
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for one scene input
// Assumes: input 0 so objects 10..19, tick of 4 cycles
// Notes:   group feedback value is the object number
`timescale 1ns/1ns
`default_nettype none
module tb_top import scene_pkg::*;;
  logic clk_i = 0, reset_i = 1, contact_i = 0, wr = 0, rd = 0, cw = 0, mute = 0;
  logic man = 0, mact = 0;  // manual operation
  logic [7:0]  addr = 8'h00;
  logic [15:0] wd = 16'h0000, cv = 16'h0000, rdata, txv, ov, ind;
  logic [6:0]  cn = 7'h00, txn, on;
  logic        txvl, txrd, rdy, ow, orsp, blk;
  int          wcnt, n, bad_count = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  scene_channel #(.TICK_CYCLES(4)) dut (.clk_i, .reset_i, .contact_i, .manual_en_i(man),
    .manual_act_i(mact), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .obj_wr_i(ow), .obj_resp_i(orsp), .obj_num_i(on), .obj_val_i(ov),
    .tx_ready_i(rdy), .tx_valid_o(txvl), .tx_read_o(txrd), .tx_num_o(txn), .tx_val_o(txv),
    .blocked_o(blk));
  bus_model bm (.clk_i, .tx_valid_i(txvl), .tx_read_i(txrd), .tx_num_i(txn), .tx_val_i(txv),
    .mute_i(mute), .cmd_wr_i(cw), .cmd_num_i(cn), .cmd_val_i(cv), .tx_ready_o(rdy),
    .obj_wr_o(ow), .obj_resp_o(orsp), .obj_num_o(on), .obj_val_o(ov), .ind_o(ind),
    .wr_cnt_o(wcnt));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // register write, one strobe cycle
  task automatic rw(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // register read, data checked in the following cycle
  task automatic rr(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // object value written from the bus
  task automatic ob(input logic [6:0] k, input logic [15:0] v);
    @(posedge clk_i);
    cn <= k;
    cv <= v;
    cw <= 1'b1;
    @(posedge clk_i);
    cw <= 1'b0;
  endtask
  // bounded wait for an indication value
  task automatic wait_ind(input logic [15:0] e);
    for (int i = 0; i < 2000 && ind !== e; i++) @(posedge clk_i);
    chk(ind, e);
    if (ind !== e) stop_test;
  endtask
  // contact held for k cycles, then released
  task automatic press(input int k);
    @(posedge clk_i) contact_i <= 1'b1;
    cyc(k);
    contact_i <= 1'b0;
    cyc(40);
  endtask
  // reset values of the register port
  task automatic t_reset;
    rr(A_CTRL, CTRL_RST);
    rr(A_TYPES, {4'h0, TYPES_RST});
    rr(A_PART, {10'h000, PART_RST});
    rr(A_PRE0, PRE_RST);
    rr(A_STAT, 16'h0000);
    rr(8'hfc, 16'h0000);
    chk(blk, 16'h0000);
  endtask
  // short press sends all six presets
  task automatic t_short;
    rw(A_CTRL, 16'h0001);
    n = wcnt;
    press(40);
    chk(16'(wcnt - n), 16'h0006);
    rr(A_SCN0, {8'h00, PCT_LUT[1]});
  endtask
  // long press reads groups back and stores them
  task automatic t_long;
    press(200);
    wait_ind(16'h0001);
    rr(A_SCN0, 16'h000b);
  endtask
  // feedback withheld, early release keeps the scene
  task automatic t_abort;
    @(posedge clk_i) mute <= 1'b1;
    press(200);
    wait_ind(16'h0000);
    rr(A_SCN0, 16'h000b);
    @(posedge clk_i) mute <= 1'b0;
  endtask
  // object mode, restore then store
  task automatic t_object;
    rw(A_CTRL, 16'h0002);
    ob(7'h13, 16'h0001);
    cyc(4);
    rr(A_SCN0, {8'h00, PCT_LUT[1]});
    ob(7'h11, 16'h0001);
    wait_ind(16'h0001);
    rr(A_SCN0 + 8'h14, 16'h0010);
  endtask
  // blocked press ignored, seen again on unblock
  task automatic t_block;
    ob(7'h0a, 16'h0001);
    cyc(3);
    chk(blk, 16'h0001);
    n = wcnt;
    @(posedge clk_i) contact_i <= 1'b1;
    cyc(40);
    chk(16'(wcnt - n), 16'h0000);
    ob(7'h0a, 16'h0000);
    cyc(40);
    chk(16'(wcnt - n), 16'h0006);
    contact_i <= 1'b0;
    cyc(40);
  endtask
  // combined mode stores only while storing is enabled
  task automatic t_both;
    rw(A_CTRL, 16'h0003);
    ob(7'h13, 16'h0001);
    ob(7'h11, 16'h0000);
    press(200);
    rr(A_SCN0, {8'h00, PCT_LUT[1]});
    ob(7'h11, 16'h0001);
    press(200);
    rr(A_SCN0, 16'h000b);
  endtask
  // manual actuation still sends while blocked
  task automatic t_manual;
    ob(7'h0a, 16'h0001);
    n = wcnt;
    man <= 1'b1;
    mact <= 1'b1;
    cyc(40);
    chk(16'(wcnt - n), 16'h0006);
    mact <= 1'b0;
    cyc(40);
    man <= 1'b0;
    ob(7'h0a, 16'h0000);
  endtask
  // opening contact type: idle open contact is an actuation
  task automatic t_open;
    n = wcnt;
    rw(A_CTRL, 16'h0400);
    cyc(40);
    chk(16'(wcnt - n), 16'h0006);
    contact_i <= 1'b1;
    cyc(40);
    chk(16'(wcnt - n), 16'h0006);
  endtask
  // wire format of each group type
  task automatic t_types;
    ob(7'h13, 16'h0001);
    rw(A_TYPES, 16'h0578);
    rw(A_PRE0 + 8'h04, 16'h00c8);
    rw(A_PRE0 + 8'h08, 16'h2710);
    rw(A_PRE0 + 8'h0c, 16'h000c);
    rr(A_SCN0, 16'h0001);
    rr(A_SCN0 + 8'h04, 16'h00c8);
    rr(A_SCN0 + 8'h08, 16'h1ce2);
    rr(A_SCN0 + 8'h0c, 16'h00ff);
  endtask
  initial begin
    cyc(6);
    reset_i <= 1'b0;
    t_reset;
    t_short;
    t_long;
    t_abort;
    t_object;
    t_block;
    t_both;
    t_manual;
    t_open;
    t_types;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
